// >>> rtl/pscg_pkg.sv
/*
  Constants and types shared by the power-save clock control block:
  register offsets, field positions, reset values, the wake delay and
  the halt sequencing states.
  Assumes a 20 MHz system clock and a 32-bit APB register bus.
*/
package pscg_pkg;

  //////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [7:0]  PSCG_ADDR_CLOCK_DIVIDER_REGISTER = 8'h00;
  localparam logic [7:0]  PSCG_ADDR_GATE1  = 8'h04;
  localparam logic [7:0]  PSCG_ADDR_STATUS = 8'h08;

  //////////////////////////////////////////////////////////////////////
  // clock_divider_register fields
  localparam int          PSCG_ROI_BIT     = 15;
  localparam int          PSCG_DOZE_MSB    = 14;
  localparam int          PSCG_DOZE_LSB    = 12;
  localparam int          PSCG_CPU_SLOWDOWN_ENABLE_BIT   = 11;
  localparam logic [2:0]  PSCG_DOZE_RESET  = 3'h0;  // ratio 1:1

  //////////////////////////////////////////////////////////////////////
  // peripheral_clock_gate_one fields
  localparam int          PSCG_T5_BIT      = 15;
  localparam int          PSCG_T4_BIT      = 14;
  localparam int          PSCG_T3_BIT      = 13;
  localparam int          PSCG_T2_BIT      = 12;
  localparam int          PSCG_T1_BIT      = 11;
  localparam int          PSCG_PWM_BIT     = 9;
  localparam int          PSCG_I2C_BIT     = 7;
  localparam int          PSCG_UART_BIT    = 5;
  localparam int          PSCG_SPI_BIT     = 3;
  localparam int          PSCG_ADC_BIT     = 0;
  localparam logic [15:0] PSCG_GATE1_MASK  = 16'hfaa9;
  localparam logic [15:0] PSCG_GATE1_RESET = 16'h0000;

  //////////////////////////////////////////////////////////////////////
  // status register fields
  localparam int          PSCG_ST_HALT     = 0;
  localparam int          PSCG_ST_SLEEP    = 1;
  localparam int          PSCG_ST_HELD     = 2;
  localparam int          PSCG_ST_DOZE     = 3;

  //////////////////////////////////////////////////////////////////////
  // timing: wake delay in clock cycles, inside the 2..4 window
  localparam int          PSCG_WAKE_CYCLES = 3;
  localparam logic [1:0]  PSCG_WAKE_LAST   = 2'(PSCG_WAKE_CYCLES - 1);

  // halt sequencing
  typedef enum logic [1:0] {
    PSCG_RUN   = 2'b00,
    PSCG_ENTER = 2'b01,
    PSCG_HALT  = 2'b10,
    PSCG_WAKE  = 2'b11
  } pscg_mode_e;

endpackage

// >>> rtl/pscg_doze_div.sv
/*
  CPU slowdown divider: a clock-enable tick once every 2**ratio
  system clocks while slowdown is on, every clock otherwise.
  Assumes enable and ratio come from registers on the same clock.
*/
`timescale 1ns/1ps
module pscg_doze_div (
  // clock and reset
  input  logic       ref_clk,
  input  logic       rst_b,
  // control
  input  logic       enable,
  input  logic [2:0] ratio,
  // cpu clock enable
  output logic       tick
);
  import pscg_pkg::*;

  typedef struct packed {
    logic [6:0] cnt;
  } pscg_div_s;

  pscg_div_s  st;
  pscg_div_s  next_st;
  logic [6:0] last;

  //////////////////////////////////////////////////////////////////////
  // count up to 2**ratio - 1, tick on the last count
  always_comb begin
    next_st = st;
    last    = 7'((8'h01 << ratio) - 8'h01);
    tick    = !enable || (st.cnt >= last);
    if (tick) begin
      next_st.cnt = 7'h00;
    end else begin
      next_st.cnt = st.cnt + 7'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  tick_period_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (enable && ratio == 3'h1 && tick) ##1 (enable && ratio == 3'h1)
      |-> !tick ##1 (!(enable && ratio == 3'h1) || tick))
    else $error("slowdown tick period wrong for ratio 1:2");

endmodule

// >>> rtl/pscg_gate_ctl.sv
/*
  Per-peripheral clock and register enables from the gate register,
  applied one cycle after the register changes.
  Assumes peripherals use clk_en as their clock gate enable.
*/
`timescale 1ns/1ps
module pscg_gate_ctl (
  // clock and reset
  input  logic        ref_clk,
  input  logic        rst_b,
  // control
  input  logic [15:0] gate_bits,
  input  logic [15:0] present,
  input  logic        sys_run,
  // peripheral enables
  output logic [15:0] clk_en,
  output logic [15:0] reg_en
);
  import pscg_pkg::*;

  typedef struct packed {
    logic [15:0] applied;
  } pscg_gate_s;

  pscg_gate_s st;
  pscg_gate_s next_st;

  //////////////////////////////////////////////////////////////////////
  // one cycle of delay between register and gate, both directions
  always_comb begin
    next_st         = st;
    next_st.applied = gate_bits;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st <= '{applied: PSCG_GATE1_RESET};
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // enables per peripheral
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_bit
      assign reg_en[i] = present[i] && !st.applied[i];
      assign clk_en[i] = reg_en[i] && sys_run;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // checks
  gate_delay_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ($rose(gate_bits[PSCG_T1_BIT]) && sys_run && present[PSCG_T1_BIT])
      |-> clk_en[PSCG_T1_BIT] ##1 !clk_en[PSCG_T1_BIT])
    else $error("gate did not apply one cycle after write");

  regs_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    gate_bits[PSCG_UART_BIT] |=> !reg_en[PSCG_UART_BIT] && !clk_en[PSCG_UART_BIT])
    else $error("gated peripheral still has register access");

  absent_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !present[PSCG_T5_BIT] |-> !clk_en[PSCG_T5_BIT] && !reg_en[PSCG_T5_BIT])
    else $error("absent peripheral enabled");

endmodule

// >>> rtl/pscg_top.sv
/*
  Power-save clock control: halt and sleep sequencing with wake-up,
  CPU slowdown by clock enable, and peripheral clock gating, with
  registers on APB.
  Assumes CPU, interrupt logic and watchdog run on ref_clk, so their
  inputs need no synchroniser.
*/
// Operation
// - halted CPU executes no instructions
// - halt entry clears the watchdog count
// - system clock and ungated peripherals run in halt
// - low-power RC clock kept if watchdog on, or monitor on outside sleep halt
// - wake on interrupt, reset or watchdog timeout
// - CPU clock restored, resume 2-4 cycles later
// - interrupt during entry deferred, then wakes immediately
// - slowdown divides only CPU clock
// - slow CPU and peripherals stay synchronized
// - slowdown only when enable bit 11 set
// - ratio bits 14:12, 1:1 to 1:128, reset 1:1
// - return-on-interrupt bit 15 restores full speed
// - disable bit stops that peripheral's clock
// - disabled peripheral registers ignore writes
// - peripheral runs only if enabled and present
// - disable change takes effect one cycle later
`timescale 1ns/1ps
module pscg_top #(
  parameter logic [15:0] PRESENT = pscg_pkg::PSCG_GATE1_MASK
) (
  // clock and reset
  input  logic        ref_clk,
  input  logic        rst_b,
  // apb slave
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // cpu and interrupt side
  input  logic        power_save_instruction_exec,
  input  logic        power_save_instruction_sleep,
  input  logic        irq_pending,
  input  logic        wdt_timeout,
  input  logic        wdt_enable,
  input  logic        clock_failure_monitor_enable,
  output logic        cpu_clk_en,
  output logic        cpu_halted,
  output logic        wdt_clear,
  // clock sources
  output logic        sys_clk_run,
  output logic        low_power_rc_clock_run,
  // peripheral side
  output logic [15:0] periph_clk_en,
  output logic [15:0] periph_reg_en
);
  import pscg_pkg::*;

  typedef struct packed {
    pscg_mode_e  mode;
    logic [1:0]  wake_cnt;
    logic        sleep;
    logic        irq_held;
    logic        return_on_interrupt;
    logic [2:0]  ratio;
    logic        cpu_slowdown_enable;
    logic [15:0] gate;
    logic [15:0] rdata;
  } pscg_state_s;

  pscg_state_s st;
  pscg_state_s next_st;
  logic        doze_tick;
  logic        wr_access;
  logic        wake_cause;
  logic        clock_divider_register_wr;

  //////////////////////////////////////////////////////////////////////
  // address decode, used for write access and error
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == PSCG_ADDR_CLOCK_DIVIDER_REGISTER) || (a == PSCG_ADDR_GATE1) ||
                  (a == PSCG_ADDR_STATUS);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // apb handshake: zero wait states
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_mapped(paddr);
  assign prdata    = {16'h0000, st.rdata};
  assign wr_access = psel && penable && pwrite && addr_mapped(paddr);
  assign clock_divider_register_wr = wr_access && (paddr == PSCG_ADDR_CLOCK_DIVIDER_REGISTER);

  // any wake source, including an interrupt held over from entry
  assign wake_cause = irq_pending || st.irq_held || wdt_timeout;

  //////////////////////////////////////////////////////////////////////
  // next state: halt sequencing, registers, read data
  always_comb begin
    next_st = st;

    // halt and sleep sequencing
    unique case (st.mode)
      PSCG_RUN: begin
        if (power_save_instruction_exec) begin
          next_st.mode  = PSCG_ENTER;
          next_st.sleep = power_save_instruction_sleep;
        end
      end
      PSCG_ENTER: begin
        next_st.mode = PSCG_HALT;  // entry completes before any wake
      end
      PSCG_HALT: begin
        if (wake_cause) begin
          next_st.mode     = PSCG_WAKE;
          next_st.wake_cnt = 2'h0;
        end
      end
      PSCG_WAKE: begin
        if (st.wake_cnt == PSCG_WAKE_LAST) begin
          next_st.mode  = PSCG_RUN;
          next_st.sleep = 1'b0;
        end else begin
          next_st.wake_cnt = st.wake_cnt + 2'h1;
        end
      end
    endcase

    // interrupt coincident with entry is held, set beats clear
    if (st.mode == PSCG_HALT && wake_cause) begin
      next_st.irq_held = 1'b0;
    end
    if (irq_pending && ((st.mode == PSCG_RUN && power_save_instruction_exec) ||
                        st.mode == PSCG_ENTER)) begin
      next_st.irq_held = 1'b1;
    end

    // register writes
    if (wr_access && paddr == PSCG_ADDR_CLOCK_DIVIDER_REGISTER) begin
      next_st.return_on_interrupt   = pwdata[PSCG_ROI_BIT];
      next_st.ratio = pwdata[PSCG_DOZE_MSB:PSCG_DOZE_LSB];
      next_st.cpu_slowdown_enable = pwdata[PSCG_CPU_SLOWDOWN_ENABLE_BIT];
    end
    if (wr_access && paddr == PSCG_ADDR_GATE1) begin
      next_st.gate = pwdata[15:0] & PSCG_GATE1_MASK;
    end

    // interrupt drops slowdown when return-on-interrupt is set
    if (st.return_on_interrupt && irq_pending && st.mode == PSCG_RUN) begin
      next_st.cpu_slowdown_enable = 1'b0;
    end

    // read data captured in the setup phase
    if (psel && !penable) begin
      next_st.rdata = 16'h0000;
      if (paddr == PSCG_ADDR_CLOCK_DIVIDER_REGISTER) begin
        next_st.rdata[PSCG_ROI_BIT]                = st.return_on_interrupt;
        next_st.rdata[PSCG_DOZE_MSB:PSCG_DOZE_LSB] = st.ratio;
        next_st.rdata[PSCG_CPU_SLOWDOWN_ENABLE_BIT]              = st.cpu_slowdown_enable;
      end else if (paddr == PSCG_ADDR_GATE1) begin
        next_st.rdata = st.gate;
      end else if (paddr == PSCG_ADDR_STATUS) begin
        next_st.rdata[PSCG_ST_HALT]  = cpu_halted;
        next_st.rdata[PSCG_ST_SLEEP] = st.sleep;
        next_st.rdata[PSCG_ST_HELD]  = st.irq_held;
        next_st.rdata[PSCG_ST_DOZE]  = st.cpu_slowdown_enable;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state register, synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st <= '{mode:     PSCG_RUN,
              wake_cnt: 2'h0,
              sleep:    1'b0,
              irq_held: 1'b0,
              return_on_interrupt:      1'b0,
              ratio:    PSCG_DOZE_RESET,
              cpu_slowdown_enable:    1'b0,
              gate:     PSCG_GATE1_RESET,
              rdata:    16'h0000};
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // cpu slowdown divider
  pscg_doze_div u_doze (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .enable  (st.cpu_slowdown_enable),
    .ratio   (st.ratio),
    .tick    (doze_tick)
  );

  // cpu runs on an enable of the one clock tree, never in halt
  assign cpu_clk_en = (st.mode == PSCG_RUN) && doze_tick;
  assign cpu_halted = (st.mode == PSCG_ENTER) || (st.mode == PSCG_HALT);
  assign wdt_clear  = (st.mode == PSCG_ENTER);

  // system clock stops only in sleep; rc clock kept for watchdog, for monitor except in sleep halt
  assign sys_clk_run = !(cpu_halted && st.sleep);
  assign low_power_rc_clock_run    = st.sleep ? (cpu_halted ? wdt_enable : (wdt_enable || clock_failure_monitor_enable))
                                : (wdt_enable || clock_failure_monitor_enable);

  //////////////////////////////////////////////////////////////////////
  // peripheral gating
  pscg_gate_ctl u_gate (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .gate_bits (st.gate),
    .present   (PRESENT),
    .sys_run   (sys_clk_run),
    .clk_en    (periph_clk_en),
    .reg_en    (periph_reg_en)
  );

  //////////////////////////////////////////////////////////////////////
  // checks
  halt_no_exec_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st.mode != PSCG_RUN) |-> !cpu_clk_en)
    else $error("cpu clock enabled while halted or waking");

  wdt_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st.mode == PSCG_RUN && power_save_instruction_exec) |=> wdt_clear ##1 !wdt_clear)
    else $error("watchdog not cleared once on halt entry");

  low_power_rc_clock_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cpu_halted && !st.sleep && (wdt_enable || clock_failure_monitor_enable)) |-> low_power_rc_clock_run)
    else $error("rc clock stopped during halt with users");

  wake_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st.mode == PSCG_HALT && (irq_pending || wdt_timeout)) |=> st.mode == PSCG_WAKE)
    else $error("halt not left on wake event");

  resume_delay_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st.mode == PSCG_HALT && wake_cause) |=> (!cpu_clk_en)[*3] ##1 (st.mode == PSCG_RUN))
    else $error("resume delay not three cycles");

  held_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st.mode == PSCG_RUN && power_save_instruction_exec && irq_pending)
      |=> (st.mode == PSCG_ENTER) ##1 (st.mode == PSCG_HALT) ##1 (st.mode == PSCG_WAKE))
    else $error("coincident interrupt not deferred then woken");

  full_speed_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!st.cpu_slowdown_enable && st.mode == PSCG_RUN) |-> cpu_clk_en)
    else $error("cpu slowed without slowdown enable");

  periph_full_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st.cpu_slowdown_enable && !cpu_halted) |-> sys_clk_run)
    else $error("system clock stopped in slowdown");

  roi_restore_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st.return_on_interrupt && irq_pending && st.mode == PSCG_RUN) |=> !st.cpu_slowdown_enable)
    else $error("interrupt did not end slowdown");

  roi_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st.cpu_slowdown_enable && !st.return_on_interrupt && !clock_divider_register_wr) |=> st.cpu_slowdown_enable)
    else $error("slowdown changed without write");

  enter_path_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st.mode == PSCG_RUN && power_save_instruction_exec)
      |=> (st.mode == PSCG_ENTER) && (st.sleep == $past(power_save_instruction_sleep)))
    else $error("power-save instruction not taken with its operand");

  halt_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st.mode == PSCG_HALT && !wake_cause) |=> st.mode == PSCG_HALT)
    else $error("halt left without a wake cause");

  idle_clk_on_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cpu_halted && !st.sleep) |-> sys_clk_run)
    else $error("system clock stopped during halt");

  sleep_clk_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cpu_halted && st.sleep) |-> !sys_clk_run && (periph_clk_en == 16'h0000))
    else $error("clocks still running in sleep");

  resume_run_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st.mode == PSCG_WAKE && st.wake_cnt == PSCG_WAKE_LAST) |=> st.mode == PSCG_RUN)
    else $error("wake delay did not end in run");

  held_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st.mode == PSCG_HALT && st.irq_held) |=> st.mode == PSCG_WAKE)
    else $error("held interrupt did not wake at once");

  cpu_slowdown_enable_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clock_divider_register_wr && !(st.return_on_interrupt && irq_pending && st.mode == PSCG_RUN))
      |=> st.cpu_slowdown_enable == $past(pwdata[PSCG_CPU_SLOWDOWN_ENABLE_BIT]))
    else $error("slowdown enable not taken from write");

  gate_store_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wr_access && paddr == PSCG_ADDR_GATE1)
      |=> st.gate == ($past(pwdata[15:0]) & PSCG_GATE1_MASK))
    else $error("gate register write not stored");

endmodule

// >>> tb/pscg_cpu_model.sv
/*
  CPU model on the far side of the power-save clock control block:
  issues the power-save instruction on request and counts the
  instructions that run.
  Assumes one clock, ref_clk, and requests from the bench at the edge.
*/
`timescale 1ns/1ps
module pscg_cpu_model (
  // clock and reset
  input  logic        ref_clk,
  input  logic        rst_b,
  // requests from the bench
  input  logic        run_psave,
  input  logic        sleep_sel,
  // cpu clock enable from the block
  input  logic        cpu_clk_en,
  // instruction stream
  output logic        power_save_instruction_exec,
  output logic        power_save_instruction_sleep,
  output logic [31:0] instr_count
);
  //////////////////////////////////////////////////////////////////////
  // instruction issue and count, one process so time zero is defined
  initial begin
    power_save_instruction_exec = 1'b0;
    power_save_instruction_sleep = 1'b0;
    instr_count = 32'h0;
    forever begin
      @(posedge ref_clk);
      if (!rst_b) begin
        power_save_instruction_exec <= 1'b0;
        instr_count <= 32'h0;
      end else begin
        power_save_instruction_exec <= run_psave & cpu_clk_en;  // issues only while running
        instr_count <= instr_count + 32'(cpu_clk_en);
      end
      // operand valid beside the instruction, toggling otherwise
      power_save_instruction_sleep <= run_psave ? sleep_sel : ~power_save_instruction_sleep;
    end
  end
endmodule

// >>> tb/tb.sv
/*
  Bench for the power-save clock control block: APB register tasks,
  gating, slowdown ratios, halt and sleep entry and wake.
  Assumes the CPU model beside it and a single 20 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb;
  import pscg_pkg::*;
  localparam logic [15:0] PRES = 16'h7aa9;  // timer5 left absent
  logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, instr_count, ic0;
  logic        irq_pending, wdt_timeout, wdt_enable, clock_failure_monitor_enable, run_psave, sleep_sel;
  logic        power_save_instruction_exec, power_save_instruction_sleep, cpu_clk_en, cpu_halted, wdt_clear;
  logic        sys_clk_run, low_power_rc_clock_run;
  logic [15:0] periph_clk_en, periph_reg_en;
  int          errors, comparisons, cnt;

  //////////////////////////////////////////////////////////////////////
  // block and cpu model
  pscg_top #(.PRESENT(PRES)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_save_instruction_exec(power_save_instruction_exec),
    .power_save_instruction_sleep(power_save_instruction_sleep), .irq_pending(irq_pending), .wdt_timeout(wdt_timeout),
    .wdt_enable(wdt_enable), .clock_failure_monitor_enable(clock_failure_monitor_enable), .cpu_clk_en(cpu_clk_en),
    .cpu_halted(cpu_halted), .wdt_clear(wdt_clear), .sys_clk_run(sys_clk_run),
    .low_power_rc_clock_run(low_power_rc_clock_run), .periph_clk_en(periph_clk_en), .periph_reg_en(periph_reg_en));
  pscg_cpu_model u_cpu (.ref_clk(ref_clk), .rst_b(rst_b), .run_psave(run_psave),
    .sleep_sel(sleep_sel), .cpu_clk_en(cpu_clk_en), .power_save_instruction_exec(power_save_instruction_exec),
    .power_save_instruction_sleep(power_save_instruction_sleep), .instr_count(instr_count));

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  //////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic final_report;
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one apb transfer, read data compared on reads
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      input logic [31:0] exp, input logic eerr);
    int n;
    logic [31:0] rdat;
    logic er;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK("pready", 1'b1, pready)
    if (!wr) `CHK("prdata", exp, rdat)
    `CHK("pslverr", eerr, er)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, e, 1'b0);
  endtask

  // count cpu clock enables over n cycles
  task automatic ticks(input int n, input int exp);
    cnt = 0;
    repeat (n) begin
      @(posedge ref_clk);
      cnt += (cpu_clk_en === 1'b1);
    end
    `CHK("cpu ticks", exp, cnt)
  endtask

  // interrupt pulse of one cycle
  task automatic pulse_irq;
    @(posedge ref_clk);
    irq_pending <= 1'b1;
    @(posedge ref_clk);
    irq_pending <= 1'b0;
  endtask

  // power-save instruction, optional coincident interrupt; ends in halt
  task automatic enter(input logic slp, input logic irq_now);
    @(posedge ref_clk);
    run_psave <= 1'b1;
    sleep_sel <= slp;
    @(posedge ref_clk);
    run_psave <= 1'b0;
    irq_pending <= irq_now;
    @(posedge ref_clk);
    #1;
    `CHK("wdt_clear", 1'b1, wdt_clear)
    `CHK("cpu_clk_en", 1'b0, cpu_clk_en)
    @(posedge ref_clk);
    #1;
    `CHK("wdt_clear", 1'b0, wdt_clear)
    `CHK("cpu_halted", 1'b1, cpu_halted)
  endtask

  // cause seen at the next edge, cpu clock back in the fourth cycle
  task automatic wake_chk;
    for (int k = 1; k <= 4; k++) begin
      @(posedge ref_clk);
      #1;
      `CHK("cpu_halted", 1'b0, cpu_halted)
      `CHK("cpu_clk_en", k == 4, cpu_clk_en)
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_b, psel, penable, pwrite, irq_pending, wdt_timeout, run_psave, sleep_sel} = '0;
    {paddr, pwdata, wdt_enable} = '0;
    clock_failure_monitor_enable = 1'b1;
    errors = 0;
    comparisons = 0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    `CHK("periph_clk_en", PRES, periph_clk_en)
    `CHK("periph_reg_en", PRES, periph_reg_en)
    `CHK("cpu_clk_en", 1'b1, cpu_clk_en)
    rd(PSCG_ADDR_CLOCK_DIVIDER_REGISTER, 32'h0);
    rd(PSCG_ADDR_GATE1, 32'h0);
    wr(PSCG_ADDR_STATUS, 32'hf);
    rd(PSCG_ADDR_STATUS, 32'h0);
    xfer(1'b1, 8'h0c, 32'h1, 32'h0, 1'b1);
    xfer(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
    // gating takes effect one cycle after the write, both ways
    wr(PSCG_ADDR_GATE1, 32'hffff);
    #1;
    `CHK("periph_clk_en", PRES, periph_clk_en)
    @(posedge ref_clk);
    #1;
    `CHK("periph_clk_en", 16'h0, periph_clk_en)
    `CHK("periph_reg_en", 16'h0, periph_reg_en)
    rd(PSCG_ADDR_GATE1, {16'h0, PSCG_GATE1_MASK});
    wr(PSCG_ADDR_GATE1, 32'h1);
    @(posedge ref_clk);
    #1;
    `CHK("periph_clk_en", PRES & 16'hfffe, periph_clk_en)
    wr(PSCG_ADDR_GATE1, 32'h0);
    #1;
    `CHK("periph_reg_en", PRES & 16'hfffe, periph_reg_en)
    @(posedge ref_clk);
    #1;
    `CHK("periph_reg_en", PRES, periph_reg_en)
    // every slowdown ratio, peripherals at full rate
    for (int r = 0; r < 8; r++) begin
      wr(PSCG_ADDR_CLOCK_DIVIDER_REGISTER, 32'(r << 12) | 32'h800);
      ticks(256, 256 >> r);
      `CHK("periph_clk_en", PRES, periph_clk_en)
    end
    rd(PSCG_ADDR_STATUS, 32'h8);
    wr(PSCG_ADDR_CLOCK_DIVIDER_REGISTER, 32'h7000);
    ticks(256, 256);
    // return on interrupt set, then clear
    wr(PSCG_ADDR_CLOCK_DIVIDER_REGISTER, 32'ha800);
    pulse_irq;
    rd(PSCG_ADDR_CLOCK_DIVIDER_REGISTER, 32'ha000);
    wr(PSCG_ADDR_CLOCK_DIVIDER_REGISTER, 32'h2800);
    pulse_irq;
    ticks(256, 64);
    rd(PSCG_ADDR_CLOCK_DIVIDER_REGISTER, 32'h2800);
    wr(PSCG_ADDR_CLOCK_DIVIDER_REGISTER, 32'h0);
    // halt, held until an interrupt
    enter(1'b0, 1'b0);
    `CHK("sys_clk_run", 1'b1, sys_clk_run)
    `CHK("periph_clk_en", PRES, periph_clk_en)
    `CHK("low_power_rc_clock_run", 1'b1, low_power_rc_clock_run)
    ic0 = instr_count;
    rd(PSCG_ADDR_STATUS, 32'h1);
    `CHK("instr_count", ic0, instr_count)
    `CHK("cpu_halted", 1'b1, cpu_halted)
    @(posedge ref_clk);
    irq_pending <= 1'b1;
    wake_chk;
    @(posedge ref_clk);
    irq_pending <= 1'b0;
    // interrupt coincident with the instruction
    enter(1'b0, 1'b1);
    wake_chk;
    @(posedge ref_clk);
    irq_pending <= 1'b0;
    // sleep, woken by watchdog time-out
    @(posedge ref_clk);
    wdt_enable <= 1'b1;
    enter(1'b1, 1'b0);
    `CHK("sys_clk_run", 1'b0, sys_clk_run)
    `CHK("low_power_rc_clock_run", 1'b1, low_power_rc_clock_run)
    @(posedge ref_clk);
    wdt_timeout <= 1'b1;
    wake_chk;
    @(posedge ref_clk);
    wdt_timeout <= 1'b0;
    // halt ended by device reset
    enter(1'b0, 1'b0);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    `CHK("cpu_halted", 1'b0, cpu_halted)
    `CHK("cpu_clk_en", 1'b1, cpu_clk_en)
    final_report;
  end

  // hang guard, far beyond the few thousand cycles the run needs
  initial begin
    #1000000;
    errors++;
    final_report;
  end
endmodule
